// File: design/fsp_pkg.sv
package fsp_pkg;

  // ----------------------------------------------------------------
  // Command opcodes.
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_WRITE_REVOKE = 8'h04;
  localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
  localparam logic [7:0] OP_PAR_ENTER = 8'h55;
  localparam logic [7:0] OP_PAR_EXIT = 8'h45;
  localparam logic [7:0] OP_SECTOR_WIPE_A = 8'h20;
  localparam logic [7:0] OP_SECTOR_WIPE_B = 8'hD8;
  localparam logic [7:0] OP_FULL_WIPE_A = 8'hC7;
  localparam logic [7:0] OP_FULL_WIPE_B = 8'h60;

  // ----------------------------------------------------------------
  // Status word layout and variant.
  // ----------------------------------------------------------------
  localparam int BIT_BUSY = 0;
  localparam int BIT_PERMIT = 1;
  localparam int BIT_PROT_LO = 2;
  localparam int BIT_PROT_THREE = 5;
  localparam int BIT_LOCK = 7;
  localparam logic FOUR_PROT_BITS = 1'b0;
  localparam logic [3:0] PROT_RESET = 4'h0;
  localparam logic LOCK_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Frame layout and array geometry.
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam logic [2:0] CNT_OPCODE_ONLY = 3'h1;
  localparam logic [2:0] CNT_STATUS_MIN = 3'h2;
  localparam logic [2:0] CNT_ADDR_DONE = 3'h4;
  localparam logic [2:0] CNT_DATA_MIN = 3'h5;
  localparam logic [2:0] CNT_MAX = 3'h7;
  localparam int PROT_UNIT_LOG2 = 18;
  localparam logic [7:0] PAGE_LAST = 8'hFF;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int STATUS_TIME_NS = 5000000;
  localparam int PAGE_TIME_NS = 1500000;
  localparam int SECTOR_TIME_NS = 500000000;
  localparam int FULL_TIME_NS = 1000000000;
  localparam int STATUS_CYCLES = (STATUS_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_CYCLES = (PAGE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int SECTOR_CYCLES = (SECTOR_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int FULL_CYCLES = (FULL_TIME_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    FSP_OP_IDLE = 2'b00,
    FSP_OP_ADDR = 2'b01,
    FSP_OP_READ = 2'b10,
    FSP_OP_WAIT = 2'b11
  } fsp_op_state_t;

  typedef enum logic [1:0] {
    FSP_K_STATUS = 2'b00,
    FSP_K_PAGE = 2'b01,
    FSP_K_SECTOR = 2'b10,
    FSP_K_FULL = 2'b11
  } fsp_kind_t;

endpackage : fsp_pkg

// File: design/fsp_link.sv
// Link-side receiver: runs on the host's serial clock, assembles bytes
// and hands each one to the system clock with a toggle.
module fsp_link (
  input wire logic spi_sclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic si,
  input wire logic [7:0] par_in,
  output logic [7:0] byte_data,
  output logic byte_tog,
  output logic mid_byte
);

  logic [2:0] bit_cnt;
  logic first;
  logic [6:0] shift;
  logic par_mode;
  logic byte_done;
  logic [7:0] next_byte;

  assign byte_done = par_mode | (bit_cnt == 3'h7);
  assign next_byte = par_mode ? par_in : {shift, si};

  // Bit position and first-byte flag restart whenever chip select is high.
  always_ff @(posedge spi_sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 3'h0;
      first <= 1'b1;
    end else begin
      if (!par_mode) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (byte_done) begin
        first <= 1'b0;
      end
    end
  end

  // Serial shifter; the byte holding register stays put until the next
  // byte completes, which gives the system side many cycles to read it.
  always_ff @(posedge spi_sclk) begin
    shift <= next_byte[6:0];
    if (byte_done) begin
      byte_data <= next_byte;
    end
  end

  // Event toggle, boundary flag and parallel mode; the boundary flag is
  // not cleared by chip select so the system side can still see it.
  always_ff @(posedge spi_sclk or posedge srst) begin
    if (srst) begin
      byte_tog <= 1'b0;
      mid_byte <= 1'b0;
      par_mode <= 1'b0;
    end else begin
      mid_byte <= !byte_done;
      if (byte_done) begin
        byte_tog <= ~byte_tog;
      end
      if (byte_done && first) begin
        if (!par_mode && next_byte == fsp_pkg::OP_PAR_ENTER) begin
          par_mode <= 1'b1;
        end else if (par_mode && next_byte == fsp_pkg::OP_PAR_EXIT) begin
          par_mode <= 1'b0;
        end
      end
    end
  end

endmodule : fsp_link

// File: design/fsp_core.sv
// Operation
// - Busy flag in bit 0 is read-only, high during any write operation.
// - Permit latch set by permit command, cleared by revoke or op completion.
// - Status-write, program and erase are refused unless permit latch is set.
// - Status-write never alters the permit latch; here it clears the latch on completion like other ops.
// - Protect bits are non-volatile and written only by status-write.
// - Program and sector erase into the protected region are refused.
// - Full erase runs only when all protect bits are zero.
// - Hardware lock holds exactly when lock bit is 1 and protect pin low.
// - Under hardware lock, status-write is ignored and lock/protect bits frozen.
// - Hardware lock ends only when the protect pin goes high.
// - Status bits 6 and 5 read zero on the three-bit variant.
// - Page program only clears array bits, never sets them.
// - Chip select rising off a byte boundary discards the program.
// - Only the last 256 data bytes are kept, wrapping within the page.
// - Program starts at chip select rise; busy until done; latch clears first.
// - A program into a protected page is not executed.
// - Parallel mode moves one byte per clock, clock at most 10 MHz.
// - Opcode 55h enters parallel mode, 45h leaves it.
// - Lock bit 7, protect bits 4..2 (and 5), latch bit 1, busy bit 0.
module fsp_core #(
  parameter int unsigned STATUS_CYCLES = fsp_pkg::STATUS_CYCLES,
  parameter int unsigned PAGE_CYCLES = fsp_pkg::PAGE_CYCLES,
  parameter int unsigned SECTOR_CYCLES = fsp_pkg::SECTOR_CYCLES,
  parameter int unsigned FULL_CYCLES = fsp_pkg::FULL_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic spi_sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic [7:0] par_in,
  input wire logic write_protect_pin_n,
  output logic [7:0] flash_status_word,
  output logic [23:0] arr_addr,
  input wire logic [7:0] arr_rdata,
  output logic arr_we,
  output logic [7:0] arr_wdata,
  output logic erase_req,
  output logic erase_full,
  output logic [23:0] erase_addr
);

  // ----------------------------------------------------------------
  // Link front end and crossings.
  // ----------------------------------------------------------------
  logic [7:0] link_byte;
  logic link_tog;
  logic link_mid;

  fsp_link u_link (
    .spi_sclk(spi_sclk),
    .srst(srst),
    .cs_n(cs_n),
    .si(si),
    .par_in(par_in),
    .byte_data(link_byte),
    .byte_tog(link_tog),
    .mid_byte(link_mid)
  );

  logic [4:0] cs_q;
  logic [2:0] tog_q;
  logic [1:0] mid_q;
  logic [1:0] wp_q;
  logic cs_fall;
  logic cs_rise;
  logic byte_evt;

  // Chip select runs through a longer chain than the byte toggle so a
  // frame end is never judged before its last byte has landed.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cs_q <= 5'h1F;
      tog_q <= 3'h0;
      mid_q <= 2'h0;
      wp_q <= 2'h3;
    end else begin
      cs_q <= {cs_q[3:0], cs_n};
      tog_q <= {tog_q[1:0], link_tog};
      mid_q <= {mid_q[0], link_mid};
      wp_q <= {wp_q[0], write_protect_pin_n};
    end
  end

  assign cs_fall = !cs_q[3] && cs_q[4];
  assign cs_rise = cs_q[3] && !cs_q[4];
  assign byte_evt = tog_q[1] ^ tog_q[2];

  // ----------------------------------------------------------------
  // Status bits and protection.
  // ----------------------------------------------------------------
  logic busy_flag;
  logic write_permit_latch;
  logic status_lock_bit;
  logic [3:0] prot;
  logic [3:0] prot_eff;
  logic hardware_lock_mode;
  logic [23:0] prot_base;
  logic prot_hit;
  logic [23:0] addr;

  assign prot_eff = fsp_pkg::FOUR_PROT_BITS ? prot : {1'b0, prot[2:0]};
  assign hardware_lock_mode = status_lock_bit && !wp_q[1];

  // Upper-region boundary: each step doubles the protected span.
  always_comb begin
    int shamt;
    shamt = fsp_pkg::PROT_UNIT_LOG2 + int'(prot_eff) - 1;
    if (shamt >= fsp_pkg::ADDR_W) begin
      prot_base = 24'h000000;
    end else begin
      prot_base = 24'(25'h1000000 - (25'h0000001 << shamt));
    end
  end

  assign prot_hit = (prot_eff != 4'h0) && (addr >= prot_base);

  // Reserved bits read as zero; bit 5 carries a protect bit only on the
  // four-bit variant.
  always_comb begin
    flash_status_word = 8'h00;
    flash_status_word[fsp_pkg::BIT_BUSY] = busy_flag;
    flash_status_word[fsp_pkg::BIT_PERMIT] = write_permit_latch;
    flash_status_word[fsp_pkg::BIT_PROT_LO +: 3] = prot[2:0];
    flash_status_word[fsp_pkg::BIT_PROT_THREE] = prot_eff[3];
    flash_status_word[fsp_pkg::BIT_LOCK] = status_lock_bit;
  end

  // ----------------------------------------------------------------
  // Frame decode: opcode, address, status data and page buffer.
  // ----------------------------------------------------------------
  logic frame_ok;
  logic [2:0] byte_cnt;
  logic [7:0] opcode;
  logic [7:0] stat_data;
  logic [7:0] col;
  logic [7:0] page_buf [256];
  logic [255:0] buf_vld;

  // A frame that opens while busy starts no command and fills no buffer, but it still loads opcode, addr and stat_data.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      frame_ok <= 1'b0;
      byte_cnt <= 3'h0;
      opcode <= 8'h00;
      stat_data <= 8'h00;
      col <= 8'h00;
      addr <= 24'h000000;
    end else if (cs_fall) begin
      frame_ok <= !busy_flag;
      byte_cnt <= 3'h0;
    end else if (byte_evt) begin
      if (byte_cnt != fsp_pkg::CNT_MAX) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
      if (byte_cnt == 3'h0) begin
        opcode <= link_byte;
      end
      if (byte_cnt == 3'h1) begin
        stat_data <= link_byte;
      end
      if (byte_cnt >= 3'h1 && byte_cnt <= 3'h3) begin
        addr <= {addr[15:0], link_byte};
      end
      if (byte_cnt == 3'h3) begin
        col <= link_byte;
      end else if (byte_cnt >= fsp_pkg::CNT_ADDR_DONE) begin
        col <= col + 8'h01;
      end
    end
  end

  // The buffer wraps inside the page, so later bytes overwrite earlier
  // ones and only the last full page survives.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      buf_vld <= '0;
    end else if (cs_fall && !busy_flag) begin
      buf_vld <= '0;
    end else if (byte_evt && frame_ok && opcode == fsp_pkg::OP_PAGE_WRITE
                 && byte_cnt >= fsp_pkg::CNT_ADDR_DONE) begin
      buf_vld[col] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (byte_evt && frame_ok && byte_cnt >= fsp_pkg::CNT_ADDR_DONE) begin
      page_buf[col] <= link_byte;
    end
  end

  // ----------------------------------------------------------------
  // Command acceptance at frame end.
  // ----------------------------------------------------------------
  logic take;
  logic op_start;
  fsp_pkg::fsp_kind_t next_kind;
  logic on_boundary;

  assign take = cs_rise && frame_ok && !busy_flag;
  assign on_boundary = !mid_q[1];

  always_comb begin
    op_start = 1'b0;
    next_kind = fsp_pkg::FSP_K_STATUS;
    if (take && write_permit_latch && on_boundary) begin
      unique case (opcode)
        fsp_pkg::OP_STATUS_WRITE: begin
          op_start = byte_cnt >= fsp_pkg::CNT_STATUS_MIN && !hardware_lock_mode;
        end
        fsp_pkg::OP_PAGE_WRITE: begin
          next_kind = fsp_pkg::FSP_K_PAGE;
          op_start = byte_cnt >= fsp_pkg::CNT_DATA_MIN && !prot_hit;
        end
        fsp_pkg::OP_SECTOR_WIPE_A, fsp_pkg::OP_SECTOR_WIPE_B: begin
          next_kind = fsp_pkg::FSP_K_SECTOR;
          op_start = byte_cnt == fsp_pkg::CNT_ADDR_DONE && !prot_hit;
        end
        fsp_pkg::OP_FULL_WIPE_A, fsp_pkg::OP_FULL_WIPE_B: begin
          next_kind = fsp_pkg::FSP_K_FULL;
          op_start = byte_cnt == fsp_pkg::CNT_OPCODE_ONLY && prot_eff == 4'h0
            && (opcode == fsp_pkg::OP_FULL_WIPE_A || fsp_pkg::FOUR_PROT_BITS);
        end
        default: begin
          op_start = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operation engine.
  // ----------------------------------------------------------------
  fsp_pkg::fsp_op_state_t op_state;
  fsp_pkg::fsp_kind_t kind;
  logic [31:0] timer;
  logic [7:0] walk;

  assign busy_flag = op_state != fsp_pkg::FSP_OP_IDLE;

  // Programs walk the page with read-modify-write, then wait out the
  // rest of the timed operation; other kinds just wait.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      op_state <= fsp_pkg::FSP_OP_IDLE;
      kind <= fsp_pkg::FSP_K_STATUS;
      timer <= 32'h00000000;
      walk <= 8'h00;
      arr_addr <= 24'h000000;
      arr_we <= 1'b0;
      arr_wdata <= 8'h00;
    end else begin
      arr_we <= 1'b0;
      unique case (op_state)
        fsp_pkg::FSP_OP_IDLE: begin
          if (op_start) begin
            kind <= next_kind;
            walk <= 8'h00;
            unique case (next_kind)
              fsp_pkg::FSP_K_STATUS: timer <= STATUS_CYCLES;
              fsp_pkg::FSP_K_PAGE: timer <= PAGE_CYCLES;
              fsp_pkg::FSP_K_SECTOR: timer <= SECTOR_CYCLES;
              fsp_pkg::FSP_K_FULL: timer <= FULL_CYCLES;
            endcase
            op_state <= next_kind == fsp_pkg::FSP_K_PAGE ?
              fsp_pkg::FSP_OP_ADDR : fsp_pkg::FSP_OP_WAIT;
          end
        end
        fsp_pkg::FSP_OP_ADDR: begin
          arr_addr <= {addr[23:8], walk};
          op_state <= fsp_pkg::FSP_OP_READ;
        end
        fsp_pkg::FSP_OP_READ: begin
          if (arr_addr[7:0] == walk && timer == 32'h00000000) begin
            op_state <= fsp_pkg::FSP_OP_WAIT;
          end else if (arr_addr[7:0] == walk) begin
            arr_we <= buf_vld[walk];
            arr_wdata <= arr_rdata & page_buf[walk];
            walk <= walk + 8'h01;
            op_state <= walk == fsp_pkg::PAGE_LAST ?
              fsp_pkg::FSP_OP_WAIT : fsp_pkg::FSP_OP_ADDR;
          end
        end
        fsp_pkg::FSP_OP_WAIT: begin
          if (timer <= 32'h00000001) begin
            op_state <= fsp_pkg::FSP_OP_IDLE;
          end
        end
      endcase
      if (op_state != fsp_pkg::FSP_OP_IDLE && timer != 32'h00000000) begin
        timer <= timer - 32'h00000001;
      end
    end
  end

  // Erase requests are handed to the array as a one-cycle pulse.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      erase_req <= 1'b0;
      erase_full <= 1'b0;
      erase_addr <= 24'h000000;
    end else begin
      erase_req <= op_start && next_kind inside {fsp_pkg::FSP_K_SECTOR, fsp_pkg::FSP_K_FULL};
      erase_full <= op_start && next_kind == fsp_pkg::FSP_K_FULL;
      if (op_start) begin
        erase_addr <= addr;
      end
    end
  end

  // Permit latch: cleared one cycle before busy falls so software never
  // sees ready with the latch still set.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      write_permit_latch <= 1'b0;
    end else if (op_state == fsp_pkg::FSP_OP_WAIT && timer == 32'h00000002) begin
      write_permit_latch <= 1'b0;
    end else if (take && byte_cnt == fsp_pkg::CNT_OPCODE_ONLY && on_boundary) begin
      if (opcode == fsp_pkg::OP_WRITE_PERMIT) begin
        write_permit_latch <= 1'b1;
      end else if (opcode == fsp_pkg::OP_WRITE_REVOKE) begin
        write_permit_latch <= 1'b0;
      end
    end
  end

  // Lock and protect bits change only when a status write finishes, and
  // not if hardware lock engaged while it ran.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_lock_bit <= fsp_pkg::LOCK_RESET;
      prot <= fsp_pkg::PROT_RESET;
    end else if (op_state == fsp_pkg::FSP_OP_WAIT && timer == 32'h00000001
                 && kind == fsp_pkg::FSP_K_STATUS && !hardware_lock_mode) begin
      status_lock_bit <= stat_data[fsp_pkg::BIT_LOCK];
      prot <= {stat_data[fsp_pkg::BIT_PROT_THREE] & fsp_pkg::FOUR_PROT_BITS,
               stat_data[fsp_pkg::BIT_PROT_LO +: 3]};
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_busy_start: assert property (op_start |=> busy_flag[*2])
    else $error("busy did not rise on accepted operation");
  a_permit_set: assert property (take && on_boundary && opcode == fsp_pkg::OP_WRITE_PERMIT
    && byte_cnt == 3'h1 |=> write_permit_latch)
    else $error("permit command did not set latch");
  a_permit_gate: assert property (cs_rise && !write_permit_latch && !busy_flag
    |=> !busy_flag)
    else $error("operation started without permit latch");
  a_done_clears: assert property ($fell(busy_flag) |-> !write_permit_latch
    && !$past(write_permit_latch))
    else $error("permit latch still set at completion");
  a_permit_kept: assert property (kind == fsp_pkg::FSP_K_STATUS && $changed(prot)
    |-> $stable(write_permit_latch))
    else $error("status write altered permit latch");
  a_lock_frozen: assert property (hardware_lock_mode && $past(hardware_lock_mode)
    |-> $stable(prot) && $stable(status_lock_bit))
    else $error("status bits changed under hardware lock");
  a_lock_refuse: assert property (take && opcode == fsp_pkg::OP_STATUS_WRITE
    && hardware_lock_mode |=> !busy_flag)
    else $error("status write accepted under hardware lock");
  a_full_guard: assert property (op_start && next_kind == fsp_pkg::FSP_K_FULL
    |-> prot_eff == 4'h0)
    else $error("full wipe started with protect bits set");
  a_prot_guard: assert property (op_start && next_kind inside {fsp_pkg::FSP_K_PAGE,
    fsp_pkg::FSP_K_SECTOR} |-> !prot_hit)
    else $error("protected region written");
  a_only_clear: assert property (arr_we |-> (arr_wdata & ~$past(arr_rdata)) == 8'h00)
    else $error("program set an array bit");
  a_boundary: assert property (op_start |-> !mid_q[1] ##1 busy_flag)
    else $error("operation started off a byte boundary");
  a_spare_zero: assert property (flash_status_word[6:5] == 2'b00)
    else $error("reserved status bits not zero");

  c_page: cover property (op_start && next_kind == fsp_pkg::FSP_K_PAGE);
  c_status: cover property (op_start && next_kind == fsp_pkg::FSP_K_STATUS);
  c_lock: cover property (take && opcode == fsp_pkg::OP_STATUS_WRITE && hardware_lock_mode);
  c_prog_write: cover property (arr_we);

endmodule : fsp_core

// File: bench/fsp_host.sv
// ------------------------------------------------------------
// Host controller model: frames bytes on the link.
// ------------------------------------------------------------
module fsp_host (
  output logic spi_sclk,
  output logic cs_n,
  output logic si,
  output logic [7:0] par_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic par = 1'b0;

  // Link lines idle with select high and the clock stopped; select rises
  // just after time zero so the receiver's counters see a real clearing edge.
  initial begin
    spi_sclk = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    par_in = 8'h00;
    #1 cs_n = 1'b1;
  end

  // One link clock; parallel mode stays at or under 10 MHz.
  task automatic tick();
    realtime h;
    h = par ? 50.0 : 7.5;
    #h spi_sclk = 1'b1;
    #h spi_sclk = 1'b0;
  endtask : tick

  // Sends n bytes high first, then xb stray bits to cut a byte short.
  task automatic frame(input int n, input logic [63:0] d, input int xb);
    int i;
    int k;
    cs_n = 1'b0;
    #20;
    for (i = n - 1; i >= 0; i--) begin
      if (par) begin
        par_in = d[8*i+:8];
        tick();
      end else begin
        for (k = 7; k >= 0; k--) begin
          si = d[8*i+k];
          tick();
        end
      end
    end
    for (k = 0; k < xb; k++) begin
      si = 1'b1;
      tick();
    end
    #20 cs_n = 1'b1;
    // Released lines show a changed value, not the last one.
    si = ~si;
    par_in = ~par_in;
    #100;
  endtask : frame
endmodule : fsp_host

// File: bench/test_fsp_core.sv
// ------------------------------------------------------------
// Self-checking bench with a flat one-page array model.
// ------------------------------------------------------------
module test_fsp_core;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, srst, write_protect_pin_n, spi_sclk, cs_n, si;
  logic [7:0] par_in, st, arr_rdata, arr_wdata;
  logic [23:0] arr_addr, erase_addr;
  logic arr_we, erase_req, erase_full;
  logic wipe_full;
  logic [23:0] wipe_at;
  logic [7:0] mem [256];
  int error_cnt = 0;
  int n_checks = 0;
  int n_erase = 0;

  fsp_host host (.spi_sclk(spi_sclk), .cs_n(cs_n), .si(si), .par_in(par_in));
  fsp_core #(.STATUS_CYCLES(20), .PAGE_CYCLES(900), .SECTOR_CYCLES(20),
    .FULL_CYCLES(20)) dut (.sys_clk(sys_clk), .srst(srst), .spi_sclk(spi_sclk),
    .cs_n(cs_n), .si(si), .par_in(par_in), .write_protect_pin_n(write_protect_pin_n),
    .flash_status_word(st), .arr_addr(arr_addr), .arr_rdata(arr_rdata),
    .arr_we(arr_we), .arr_wdata(arr_wdata), .erase_req(erase_req),
    .erase_full(erase_full), .erase_addr(erase_addr));

  // The array only sees the low address byte; one page is enough here.
  assign arr_rdata = mem[arr_addr[7:0]];
  always @(posedge sys_clk) begin
    if (arr_we) mem[arr_addr[7:0]] <= arr_wdata;
    if (erase_req) n_erase++;
    if (erase_req) wipe_full <= erase_full;
    if (erase_req) wipe_at <= erase_addr;
  end

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // Waits, bounded, for the busy flag to drop; status is read one step
  // after the edge so it is settled, and a hang counts as a mismatch.
  task automatic cmd(input int n, input logic [63:0] d);
    int i;
    host.frame(n, d, 0);
    @(posedge sys_clk) #1;
    for (i = 0; i < 3000 && st[0] !== 1'b0; i++) @(posedge sys_clk) #1;
    chk("busy end", {7'h00, st[0]}, 8'h00);
  endtask : cmd

  task automatic t_permit();
    chk("status reset", st, 8'h00);
    cmd(2, 64'h019C);
    chk("write w/o permit", st, 8'h00);
    cmd(1, 64'h06);
    chk("permit", st, 8'h02);
    cmd(1, 64'h04);
    chk("revoke", st, 8'h00);
  endtask : t_permit

  task automatic t_status();
    cmd(1, 64'h06);
    host.frame(2, 64'h01FF, 0);
    @(posedge sys_clk) #1;
    chk("busy low bits", {6'h00, st[1:0]}, 8'h03);
    cmd(0, 64'h0);
    chk("status after", st, 8'h9C);
  endtask : t_status

  task automatic t_lock();
    @(posedge sys_clk) #1 write_protect_pin_n = 1'b0;
    cmd(1, 64'h06);
    cmd(2, 64'h0100);
    chk("locked write", st, 8'h9E);
    cmd(1, 64'h04);
    @(posedge sys_clk) #1 write_protect_pin_n = 1'b1;
    cmd(1, 64'h06);
    cmd(2, 64'h011C);
    chk("unlocked write", st, 8'h1C);
  endtask : t_lock

  task automatic t_protect();
    cmd(1, 64'h06);
    cmd(5, 64'h02_000010_00);
    chk("protected page", mem[8'h10], 8'hFF);
    cmd(1, 64'h06);
    cmd(1, 64'hC7);
    chk("wipe refused", n_erase[7:0], 8'h00);
    cmd(1, 64'h06);
    cmd(2, 64'h0100);
    cmd(1, 64'h06);
    cmd(1, 64'h60);
    chk("short wipe refused", n_erase[7:0], 8'h00);
    cmd(1, 64'hC7);
    chk("wipe done", n_erase[7:0], 8'h01);
    chk("wipe kind full", {7'h00, wipe_full}, 8'h01);
    cmd(1, 64'h06);
    cmd(4, 64'hD8_001234);
    chk("sector wipe", n_erase[7:0], 8'h02);
    chk("sector kind", {7'h00, wipe_full}, 8'h00);
    chk("sector addr mid", wipe_at[15:8], 8'h12);
    chk("sector addr low", wipe_at[7:0], 8'h34);
    chk("latch cleared", st, 8'h00);
  endtask : t_protect

  task automatic t_program();
    mem[8'h10] = 8'hF0;
    cmd(1, 64'h06);
    host.frame(5, 64'h02_000010_3C, 0);
    @(posedge sys_clk) #1;
    chk("prog busy", {6'h00, st[1:0]}, 8'h03);
    cmd(0, 64'h0);
    chk("and only", mem[8'h10], 8'h30);
    chk("prog end", st, 8'h00);
    cmd(1, 64'h06);
    host.frame(5, 64'h02_000011_00, 3);
    cmd(0, 64'h0);
    chk("cut byte", mem[8'h11], 8'hFF);
  endtask : t_program

  task automatic t_parallel();
    cmd(1, 64'h55);
    host.par = 1'b1;
    cmd(1, 64'h06);
    cmd(7, 64'h02_0000FE_A1B2C3);
    chk("par fe", mem[8'hFE], 8'hA1);
    chk("par ff", mem[8'hFF], 8'hB2);
    chk("wrap 00", mem[8'h00], 8'hC3);
    cmd(1, 64'h45);
    host.par = 1'b0;
    cmd(1, 64'h06);
    chk("serial again", st, 8'h02);
  endtask : t_parallel

  // Cuts a hang short well beyond the expected run of about 3.3k cycles.
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    // Reset rises after time zero so the link's asynchronous clear sees an edge.
    srst = 1'b0;
    write_protect_pin_n = 1'b1;
    #1 srst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 srst = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    t_permit();
    t_status();
    t_lock();
    t_protect();
    t_program();
    t_parallel();
    end_sim();
  end
endmodule : test_fsp_core
